/* core/ssf_clamp.sv */
// range check with saturation or wraparound to a 16-, 32- or 40-bit destination
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_clamp import ssf_pkg::*; #(
  parameter int IN_W = 48
) (
  // true result and mode
  input  logic [IN_W-1:0] value,
  input  ssf_width_t      width,
  input  logic            saturate,
  // destination value, sign-extended to 40 bits
  output logic [39:0]     result,
  output logic            out_of_range
);
  // true when the signed value fits in w bits
  function automatic logic fits(input logic [IN_W-1:0] v, input int w);
    logic signed [IN_W-1:0] hi;
    hi = $signed(v) >>> (w - 1);
    fits = (hi == '0) || (hi == '1);
  endfunction

  logic       neg;
  logic       fit16;
  logic       fit32;
  logic       fit40;
  logic [39:0] wrap16;
  logic [39:0] wrap32;
  logic [39:0] lim16;
  logic [39:0] lim32;
  logic [39:0] lim40;

  // range tests; 1.15, 1.31 and 9.31 share the sign bit at the top of each width
  // binal point
  assign neg   = value[IN_W-1];
  assign fit16 = fits(value, 16);
  assign fit32 = fits(value, 32);
  assign fit40 = fits(value, 40);

  // wrapped results keep only the low bits
  // keep low bits
  assign wrap16 = {{24{value[15]}}, value[15:0]};
  assign wrap32 = {{8{value[31]}}, value[31:0]};

  // clamp values follow the sign of the true result
  // sign-true clamp
  assign lim16 = neg ? {24'hff_ffff, `SSF_NEG16} : {24'h00_0000, `SSF_POS16};
  assign lim32 = neg ? {8'hff, `SSF_NEG32} : {8'h00, `SSF_POS32};
  assign lim40 = neg ? `SSF_NEG40 : `SSF_POS40;

  // select per width
  assign out_of_range = (width == SSF_W16) ? !fit16 : (width == SSF_W32) ? !fit32 : !fit40;
  assign result = (width == SSF_W16) ? (fit16 ? wrap16 : (saturate ? lim16 : wrap16)) :
                  (width == SSF_W32) ? (fit32 ? wrap32 : (saturate ? lim32 : wrap32)) :
                  (fit40 ? value[39:0] : (saturate ? lim40 : value[39:0]));
endmodule

/* core/ssf_core.sv */
// accumulators, address-generator register sets and arithmetic status flags
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_core import ssf_pkg::*; #(
  parameter int VAL_W = 48
) (
  // clock and reset
  input  logic                   clock,
  input  logic                   arst_n,
  // register port
  input  logic [`SSF_ADDR_W-1:0] addr,
  input  logic [31:0]            wdata,
  input  logic                   wr_en,
  input  logic                   rd_en,
  output logic [31:0]            rdata_reg,
  // operation from the execute pipeline
  input  logic                   op_valid,
  input  ssf_dst_t               op_dest,
  input  logic [1:0]             op_index,
  input  logic [VAL_W-1:0]       op_value,
  input  logic                   op_saturate,
  input  logic                   op_sat32,
  input  logic                   op_wrap,
  input  logic                   op_carry0,
  input  logic                   op_carry1,
  input  logic                   op_quot,
  input  logic                   cond_we,
  input  logic                   cond_val,
  // results and state
  output logic [39:0]            result_reg,
  output logic                   result_valid_reg,
  output logic [`SSF_STAT_W-1:0] stat_reg,
  output logic [1:0][39:0]       acc_reg,
  output logic [3:0][31:0]       mod_reg,
  output logic [3:0][31:0]       len_reg,
  output logic [3:0][31:0]       base_reg
);
  // read one part of an accumulator
  function automatic logic [31:0] acc_read(input logic [39:0] a, input logic [1:0] p);
    unique case (p)
      `SSF_PART_WORD: acc_read = a[31:0];
      `SSF_PART_HIGH: acc_read = {16'h0000, a[31:16]};
      `SSF_PART_LOW:  acc_read = {16'h0000, a[15:0]};
      `SSF_PART_EXT:  acc_read = {24'h00_0000, a[39:32]};
    endcase
  endfunction

  // write one part of an accumulator; a word write sign-extends into the extension
  function automatic logic [39:0] acc_write(input logic [39:0] a, input logic [1:0] p,
                                            input logic [31:0] d);
    unique case (p)
      `SSF_PART_WORD: acc_write = {{8{d[31]}}, d};
      `SSF_PART_HIGH: acc_write = {a[39:32], d[15:0], a[15:0]};
      `SSF_PART_LOW:  acc_write = {a[39:16], d[15:0]};
      `SSF_PART_EXT:  acc_write = {d[7:0], a[31:0]};
    endcase
  endfunction

  logic [1:0]            part;
  logic [1:0]            ridx;
  logic                  aligned;
  logic [1:0]            hit_acc;
  logic                  hit_mod;
  logic                  hit_len;
  logic                  hit_base;
  logic                  hit_stat;
  logic                  stat_wr;
  logic [31:0]           rd_mux;
  ssf_width_t            cl_width;
  logic                  cl_sat;
  logic [39:0]           cl_result;
  logic                  cl_oor;
  logic                  arith;
  logic                  to_acc0;
  logic                  to_acc1;
  logic                  to_dreg;
  logic                  ovf_now;
  logic [`SSF_STAT_W-1:0] stat_base;
  logic [`SSF_STAT_W-1:0] stat_next;

  // address decode; word-aligned offsets only, unmapped reads return zero
  assign part     = addr[3:2];
  assign ridx     = addr[3:2];
  assign aligned  = (addr[1:0] == 2'h0);
  assign hit_mod  = aligned && (addr[7:4] == 4'(`SSF_OFF_MOD >> 4));
  assign hit_len  = aligned && (addr[7:4] == 4'(`SSF_OFF_LEN >> 4));
  assign hit_base = aligned && (addr[7:4] == 4'(`SSF_OFF_BASE >> 4));
  assign hit_stat = (addr == `SSF_OFF_STAT);
  assign stat_wr  = wr_en && hit_stat;

  // one decode per accumulator
  // accumulator parts
  for (genvar g = 0; g < 2; g++) begin : g_acc_hit
    assign hit_acc[g] = aligned && (addr[7:4] == 4'((g == 0) ? `SSF_OFF_ACC0 >> 4 : `SSF_OFF_ACC1 >> 4));
  end

  // read data selection
  assign rd_mux = hit_acc[0] ? acc_read(acc_reg[0], part) :
                  hit_acc[1] ? acc_read(acc_reg[1], part) :
                  hit_mod    ? mod_reg[ridx] :
                  hit_len    ? len_reg[ridx] :
                  hit_base   ? base_reg[ridx] :
                  hit_stat   ? {20'h0_0000, stat_reg} : 32'h0000_0000;

  // operation classes
  // section binding
  assign to_acc0 = op_valid && (op_dest == SSF_DST_ACC0);
  assign to_acc1 = op_valid && (op_dest == SSF_DST_ACC1);
  assign to_dreg = op_valid && ((op_dest == SSF_DST_DREG32) || (op_dest == SSF_DST_DREG16));
  assign arith   = to_acc0 || to_acc1 || to_dreg;

  // accumulators clamp to 40 bits, or to 32 in the optional mode; op_wrap is the rare
  // instruction that lets an accumulator overflow instead
  // accumulator saturation
  assign cl_width = (to_acc0 || to_acc1) ? (op_sat32 ? SSF_W32 : SSF_W40) :
                    (op_dest == SSF_DST_DREG16) ? SSF_W16 : SSF_W32;
  assign cl_sat   = (to_acc0 || to_acc1) ? !op_wrap : op_saturate;

  ssf_clamp #(
    .IN_W (VAL_W)
  ) u_clamp (
    .value        (op_value),
    .width        (cl_width),
    .saturate     (cl_sat),
    .result       (cl_result),
    .out_of_range (cl_oor)
  );

  // overflow only when the value wrapped
  // no overflow when saturating
  assign ovf_now = cl_oor && !cl_sat;

  // software write loads the flags; an arithmetic operation in the same cycle overrides the flags it updates
  assign stat_base = stat_wr ? wdata[`SSF_STAT_W-1:0] : stat_reg;

  // next status flags, all active high
  // flag update
  always_comb begin
    stat_next = stat_base;
    if (arith) begin
      stat_next[`SSF_FLG_CARRY0] = op_carry0;
      stat_next[`SSF_FLG_CARRY1] = op_carry1;
      stat_next[`SSF_FLG_QUOT]   = op_quot;
      stat_next[`SSF_FLG_NEG]    = cl_result[39];
      stat_next[`SSF_FLG_ZERO]   = (cl_result == 40'h00_0000_0000);
    end
    if (to_acc0) begin
      stat_next[`SSF_FLG_OVF0] = ovf_now;
    end
    if (to_acc1) begin
      stat_next[`SSF_FLG_OVF1] = ovf_now;
    end
    if (to_dreg) begin
      stat_next[`SSF_FLG_OVFD] = ovf_now;
    end
    // sticky bits: a set in the clearing cycle wins over the clear
    // acc0, acc1 and data sticky
    stat_next[`SSF_FLG_STK0] = stat_base[`SSF_FLG_STK0] || (to_acc0 && ovf_now);
    stat_next[`SSF_FLG_STK1] = stat_base[`SSF_FLG_STK1] || (to_acc1 && ovf_now);
    stat_next[`SSF_FLG_STKD] = stat_base[`SSF_FLG_STKD] || (to_dreg && ovf_now);
    if (cond_we) begin
      stat_next[`SSF_FLG_COND] = cond_val;
    end
  end

  // status register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= `SSF_STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // result port and read data; read data stand in the cycle after each cycle that rd_en is high, zero otherwise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_reg       <= 40'h00_0000_0000;
      result_valid_reg <= 1'b0;
      rdata_reg        <= 32'h0000_0000;
    end else begin
      result_reg       <= arith ? cl_result : result_reg;
      result_valid_reg <= arith;
      rdata_reg        <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // accumulators; the pipeline wins over a register write in the same cycle
  // accumulator update
  for (genvar g = 0; g < 2; g++) begin : g_acc
    logic op_hit;
    assign op_hit = (g == 0) ? to_acc0 : to_acc1;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        acc_reg[g] <= 40'h00_0000_0000;
      end else if (op_hit) begin
        acc_reg[g] <= cl_result;
      end else if (wr_en && hit_acc[g]) begin
        acc_reg[g] <= acc_write(acc_reg[g], part, wdata);
      end
    end
  end

  // address-generator register sets; these never touch the flags
  // register sets
  for (genvar g = 0; g < 4; g++) begin : g_agen
    logic op_m;
    logic op_l;
    logic op_b;
    assign op_m = op_valid && (op_dest == SSF_DST_MOD) && (op_index == 2'(g));
    assign op_l = op_valid && (op_dest == SSF_DST_LEN) && (op_index == 2'(g));
    assign op_b = op_valid && (op_dest == SSF_DST_BASE) && (op_index == 2'(g));
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        mod_reg[g]  <= 32'h0000_0000;
        len_reg[g]  <= 32'h0000_0000;
        base_reg[g] <= 32'h0000_0000;
      end else begin
        if (op_m || (wr_en && hit_mod && ridx == 2'(g))) begin
          mod_reg[g] <= op_m ? op_value[31:0] : wdata;
        end
        if (op_l || (wr_en && hit_len && ridx == 2'(g))) begin
          len_reg[g] <= op_l ? op_value[31:0] : wdata;
        end
        if (op_b || (wr_en && hit_base && ridx == 2'(g))) begin
          base_reg[g] <= op_b ? op_value[31:0] : wdata;
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic signed [VAL_W-1:0] sv;
  assign sv = $signed(op_value);

  // sticky bit follows its overflow flag
  property p_stk0_set;
    to_acc0 && ovf_now |=> stat_reg[`SSF_FLG_OVF0] && stat_reg[`SSF_FLG_STK0];
  endproperty
  a_stk0_set: assert property (p_stk0_set) else $error("acc0 sticky not set");

  property p_stk1_hold;
    stat_reg[`SSF_FLG_STK1] && !stat_wr |=> stat_reg[`SSF_FLG_STK1];
  endproperty
  a_stk1_hold: assert property (p_stk1_hold) else $error("acc1 sticky dropped");

  property p_stkd_set;
    to_dreg && ovf_now ##1 stat_reg[`SSF_FLG_STKD] && !stat_wr |=> stat_reg[`SSF_FLG_STKD];
  endproperty
  a_stkd_set: assert property (p_stkd_set) else $error("data sticky not held");

  property p_addr_quiet;
    op_valid && !arith && !stat_wr && !cond_we |=> $stable(stat_reg);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address op changed flags");

  property p_sat_no_ovf;
    to_dreg && op_saturate && !stat_wr |=> !stat_reg[`SSF_FLG_OVFD];
  endproperty
  a_sat_no_ovf: assert property (p_sat_no_ovf) else $error("overflow set on saturation");

  property p_sat16;
    op_valid && op_dest == SSF_DST_DREG16 && op_saturate && sv > 48'sh7fff
      |=> result_reg[15:0] == `SSF_POS16 && !stat_reg[`SSF_FLG_NEG];
  endproperty
  a_sat16: assert property (p_sat16) else $error("16-bit clamp wrong");

  property p_sat32_neg;
    op_valid && op_dest == SSF_DST_DREG32 && op_saturate && sv < -48'sh8000_0000
      |=> result_reg[31:0] == `SSF_NEG32;
  endproperty
  a_sat32_neg: assert property (p_sat32_neg) else $error("32-bit negative clamp wrong");

  property p_acc40;
    to_acc0 && !op_wrap && !op_sat32 && sv > 48'sh7f_ffff_ffff |=> acc_reg[0] == `SSF_POS40;
  endproperty
  a_acc40: assert property (p_acc40) else $error("accumulator 40-bit clamp wrong");

  property p_wrap32;
    op_valid && op_dest == SSF_DST_DREG32 && !op_saturate && cl_oor
      |=> result_reg[31:0] == $past(op_value[31:0]) && stat_reg[`SSF_FLG_OVFD];
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("data wrap or overflow wrong");

  property p_read;
    rd_en && hit_stat |=> rdata_reg == {20'h0_0000, $past(stat_reg)} ##1 rdata_reg == 32'h0 || $past(rd_en);
  endproperty
  a_read: assert property (p_read) else $error("status read data wrong");

  // acc0 sticky survives everything but a software write
  property p_stk0_hold;
    stat_reg[`SSF_FLG_STK0] && !stat_wr |=> stat_reg[`SSF_FLG_STK0];
  endproperty
  a_stk0_hold: assert property (p_stk0_hold) else $error("acc0 sticky dropped");

  // section one never disturbs accumulator zero
  property p_acc1_keeps_acc0;
    to_acc1 && !(wr_en && hit_acc[0]) |=> $stable(acc_reg[0]);
  endproperty
  a_acc1_keeps_acc0: assert property (p_acc1_keeps_acc0) else $error("acc1 op moved acc0");

  // condition bit takes the written value
  property p_cond_set;
    cond_we |=> stat_reg[`SSF_FLG_COND] == $past(cond_val);
  endproperty
  a_cond_set: assert property (p_cond_set) else $error("condition bit not written");

  // arithmetic leaves the condition bit alone
  property p_cond_hold;
    !cond_we && !stat_wr |=> $stable(stat_reg[`SSF_FLG_COND]);
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("condition bit moved");

  // a wrapped data result of zero raises zero and clears negative
  property p_zero_flag;
    op_valid && op_dest == SSF_DST_DREG32 && !op_saturate && op_value[31:0] == 32'h0000_0000
      |=> stat_reg[`SSF_FLG_ZERO] && !stat_reg[`SSF_FLG_NEG];
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  // positive 32-bit overflow clamps to the top value
  property p_sat32_pos;
    op_valid && op_dest == SSF_DST_DREG32 && op_saturate && sv > 48'sh7fff_ffff
      |=> result_reg[31:0] == `SSF_POS32 && !stat_reg[`SSF_FLG_NEG];
  endproperty
  a_sat32_pos: assert property (p_sat32_pos) else $error("32-bit positive clamp wrong");

  // negative 40-bit overflow clamps to the bottom value
  property p_sat40_neg;
    to_acc1 && !op_wrap && !op_sat32 && sv < -48'sh80_0000_0000 |=> acc_reg[1] == `SSF_NEG40;
  endproperty
  a_sat40_neg: assert property (p_sat40_neg) else $error("40-bit negative clamp wrong");

  // optional mode holds the accumulator inside the 32-bit range
  property p_acc_sat32;
    to_acc0 && !op_wrap && op_sat32 && sv > 48'sh7fff_ffff |=> acc_reg[0] == {8'h00, `SSF_POS32};
  endproperty
  a_acc_sat32: assert property (p_acc_sat32) else $error("accumulator 32-bit clamp wrong");

  // main scenarios
  c_acc_clamp: cover property (to_acc1 && cl_oor && cl_sat);
  c_dreg_wrap: cover property (to_dreg && ovf_now ##1 stat_wr);
  c_sat32_mode: cover property (to_acc0 && op_sat32 && cl_oor);
  c_agen_write: cover property (op_valid && op_dest == SSF_DST_LEN);
endmodule

/* core/ssf_pkg.sv */
// types shared by the saturation and flag block
package ssf_pkg;
  // destination class of an issued operation
  typedef enum logic [3:0] {
    SSF_DST_NONE,
    SSF_DST_ACC0,
    SSF_DST_ACC1,
    SSF_DST_DREG32,
    SSF_DST_DREG16,
    SSF_DST_MOD,
    SSF_DST_LEN,
    SSF_DST_BASE,
    SSF_DST_PTR
  } ssf_dst_t;
  // destination width for clamping
  typedef enum logic [1:0] {
    SSF_W16,
    SSF_W32,
    SSF_W40
  } ssf_width_t;
endpackage

/* core/ssf_regs.svh */
// register offsets, flag positions, limits and reset values of the saturation and flag block
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
`define SSF_ADDR_W    8
`define SSF_OFF_ACC0  8'h00
`define SSF_OFF_ACC1  8'h10
`define SSF_OFF_MOD   8'h20
`define SSF_OFF_LEN   8'h30
`define SSF_OFF_BASE  8'h40
`define SSF_OFF_STAT  8'h50
`define SSF_PART_WORD 2'h0
`define SSF_PART_HIGH 2'h1
`define SSF_PART_LOW  2'h2
`define SSF_PART_EXT  2'h3
`define SSF_FLG_CARRY0 0
`define SSF_FLG_CARRY1 1
`define SSF_FLG_NEG    2
`define SSF_FLG_QUOT   3
`define SSF_FLG_ZERO   4
`define SSF_FLG_OVF0   5
`define SSF_FLG_STK0   6
`define SSF_FLG_OVF1   7
`define SSF_FLG_STK1   8
`define SSF_FLG_COND   9
`define SSF_FLG_OVFD   10
`define SSF_FLG_STKD   11
`define SSF_STAT_W     12
`define SSF_STAT_RST   12'h000
`define SSF_POS16 16'h7fff
`define SSF_NEG16 16'h8000
`define SSF_POS32 32'h7fff_ffff
`define SSF_NEG32 32'h8000_0000
`define SSF_POS40 40'h7f_ffff_ffff
`define SSF_NEG40 40'h80_0000_0000
`endif

/* test/ssf_pipe_model.sv */
// execute-pipeline stand-in that issues operations to the flag block
`timescale 1ns/1ps
module ssf_pipe_model import ssf_pkg::*; (
  // clock
  input  logic        clock,
  // operation port
  output logic        op_valid,
  output ssf_dst_t    op_dest,
  output logic [1:0]  op_index,
  output logic [47:0] op_value,
  output logic        op_saturate,
  output logic        op_sat32,
  output logic        op_wrap,
  output logic        op_carry0,
  output logic        op_carry1,
  output logic        op_quot,
  // condition bit port
  output logic        cond_we,
  output logic        cond_val
);
  // idle values at time zero; the operand bus carries a pattern, not zero
  initial begin
    op_valid    = 1'b0;
    op_dest     = SSF_DST_NONE;
    op_index    = 2'h0;
    op_value    = 48'h5555_aaaa_5555;
    op_saturate = 1'b0;
    op_sat32    = 1'b0;
    op_wrap     = 1'b0;
    {op_quot, op_carry1, op_carry0} = 3'h0;
    cond_we     = 1'b0;
    cond_val    = 1'b0;
  end

  // one operation for one cycle; cq is {quotient, carry1, carry0}
  task automatic issue(input ssf_dst_t dst, input logic [1:0] idx, input logic [47:0] val,
                       input logic sat, input logic s32, input logic wrp, input logic [2:0] cq);
    @(posedge clock);
    op_valid    <= 1'b1;
    op_dest     <= dst;
    op_index    <= idx;
    op_value    <= val;
    op_saturate <= sat;
    op_sat32    <= s32;
    op_wrap     <= wrp;
    {op_quot, op_carry1, op_carry0} <= cq;
    @(posedge clock);
    op_valid <= 1'b0;
    op_value <= ~val; // a stale operand must not look valid
    op_dest  <= SSF_DST_NONE;
  endtask

  // one-cycle write of the condition bit
  task automatic set_cond(input logic v);
    @(posedge clock);
    cond_we  <= 1'b1;
    cond_val <= v;
    @(posedge clock);
    cond_we  <= 1'b0;
    cond_val <= ~v;
  endtask
endmodule

/* test/tb.sv */
// self-checking bench for the saturation and status flag block
`timescale 1ns/1ps
module tb import ssf_pkg::*;;
  // register port and clocking
  logic             clock;
  logic             arst_n;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr_en;
  logic             rd_en;
  logic [31:0]      rdata_reg;
  // operation port
  logic             op_valid, op_saturate, op_sat32, op_wrap;
  logic             op_carry0, op_carry1, op_quot, cond_we, cond_val;
  ssf_dst_t         op_dest;
  logic [1:0]       op_index;
  logic [47:0]      op_value;
  // results
  logic [39:0]      result_reg;
  logic             result_valid_reg;
  logic [11:0]      stat_reg;
  logic [1:0][39:0] acc_reg;
  logic [3:0][31:0] mod_reg, len_reg, base_reg;
  int               num_errors;
  int               checks;

  ssf_core uut (
    .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_reg(rdata_reg), .op_valid(op_valid), .op_dest(op_dest), .op_index(op_index),
    .op_value(op_value), .op_saturate(op_saturate), .op_sat32(op_sat32), .op_wrap(op_wrap),
    .op_carry0(op_carry0), .op_carry1(op_carry1), .op_quot(op_quot), .cond_we(cond_we),
    .cond_val(cond_val), .result_reg(result_reg), .result_valid_reg(result_valid_reg),
    .stat_reg(stat_reg), .acc_reg(acc_reg), .mod_reg(mod_reg), .len_reg(len_reg), .base_reg(base_reg)
  );

  ssf_pipe_model pm (
    .clock(clock), .op_valid(op_valid), .op_dest(op_dest), .op_index(op_index), .op_value(op_value),
    .op_saturate(op_saturate), .op_sat32(op_sat32), .op_wrap(op_wrap), .op_carry0(op_carry0),
    .op_carry1(op_carry1), .op_quot(op_quot), .cond_we(cond_we), .cond_val(cond_val)
  );

  // 50 ns core clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // compare tasks, one per kind of result
  task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flags(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus cycles; the write lands at the edge that samples the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata_reg;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    wr(8'h00, 32'h8000_0001);
    chk_val("acc0 word", 40'hff_8000_0001, acc_reg[0]);
    rd(8'h0c, d);
    chk_val("acc0 ext", 40'hff, {8'h0, d});
    wr(8'h04, 32'h0000_1234);
    wr(8'h0c, 32'h0000_0005);
    chk_val("acc0 parts", 40'h05_1234_0001, acc_reg[0]);
    rd(8'h08, d);
    chk_val("acc0 low", 40'h1, {8'h0, d});
    @(posedge clock);
    #1;
    chk_val("rdata idle", 40'h0, {8'h0, rdata_reg});
    wr(8'h10, 32'h0000_00aa);
    chk_val("acc1 word", 40'haa, acc_reg[1]);
    wr(8'h28, 32'hdead_0001);
    rd(8'h28, d);
    chk_val("offset 2", 40'hdead_0001, {8'h0, d});
    wr(8'h34, 32'h0000_0100);
    chk_val("length 1", 40'h100, {8'h0, len_reg[1]});
    wr(8'h4c, 32'h0000_8000);
    chk_val("base 3", 40'h8000, {8'h0, base_reg[3]});
    rd(8'h60, d);
    chk_val("unmapped", 40'h0, {8'h0, d});
    $display("test regs done");
  endtask

  task automatic t_data;
    logic [31:0] d;
    wr(8'h50, 32'h0);
    pm.issue(SSF_DST_DREG32, 2'h0, 48'h0001_0000_0000, 1'b0, 1'b0, 1'b0, 3'h0);
    #1;
    chk_val("wrap result", 40'h0, result_reg);
    chk_val("result valid", 40'h1, {39'h0, result_valid_reg});
    chk_flags("wrap flags", 12'hc10, stat_reg);
    pm.issue(SSF_DST_DREG32, 2'h0, 48'hffff_ffff_fffb, 1'b0, 1'b0, 1'b0, 3'h0);
    #1;
    chk_val("neg result", 40'hff_ffff_fffb, result_reg);
    chk_flags("sticky held", 12'h804, stat_reg);
    wr(8'h50, 32'h0);
    rd(8'h50, d);
    chk_flags("sticky clear", 12'h0, d[11:0]);
    $display("test data done");
  endtask

  task automatic t_acc;
    pm.issue(SSF_DST_ACC0, 2'h0, 48'h0100_0000_0001, 1'b0, 1'b0, 1'b1, 3'h0);
    #1;
    chk_val("acc0 wrap", 40'h1, acc_reg[0]);
    chk_flags("acc0 ovf", 12'h060, stat_reg);
    pm.issue(SSF_DST_ACC1, 2'h0, 48'h0080_0000_0000, 1'b0, 1'b0, 1'b1, 3'h0);
    #1;
    chk_val("acc1 wrap", 40'h80_0000_0000, acc_reg[1]);
    chk_flags("acc1 ovf", 12'h1e4, stat_reg);
    pm.issue(SSF_DST_ACC0, 2'h0, 48'h3, 1'b0, 1'b0, 1'b1, 3'h7);
    #1;
    chk_flags("acc0 sticky", 12'h1cb, stat_reg);
    $display("test acc done");
  endtask

  // address-register operations try to move both carry flags and the negative flag
  task automatic t_agen;
    for (int i = 5; i <= 8; i++) begin
      pm.issue(ssf_dst_t'(i), 2'h1, 48'hffff_ffff_ffff, 1'b0, 1'b0, 1'b1, 3'h4);
      #1;
      chk_flags("agen flags", 12'h1cb, stat_reg);
    end
    pm.set_cond(1'b1);
    #1;
    chk_flags("cond set", 12'h3cb, stat_reg);
    pm.set_cond(1'b0);
    #1;
    chk_flags("cond clear", 12'h1cb, stat_reg);
    $display("test agen done");
  endtask

  task automatic sat_case(input ssf_dst_t dst, input logic s32, input logic [47:0] v, input logic [39:0] exp);
    pm.issue(dst, 2'h0, v, 1'b1, s32, 1'b0, 3'h0);
    #1;
    chk_val("sat result", exp, result_reg);
    chk_flags("sat flags", {9'h0, exp[39], 2'h0}, stat_reg);
  endtask

  task automatic t_sat;
    wr(8'h50, 32'h0);
    sat_case(SSF_DST_DREG16, 1'b0, 48'h0000_0001_0000, 40'h00_0000_7fff);
    sat_case(SSF_DST_DREG16, 1'b0, 48'hffff_ffff_0000, 40'hff_ffff_8000);
    sat_case(SSF_DST_DREG32, 1'b0, 48'h0001_0000_0000, 40'h00_7fff_ffff);
    sat_case(SSF_DST_DREG32, 1'b0, 48'hfffe_ffff_ffff, 40'hff_8000_0000);
    sat_case(SSF_DST_ACC0, 1'b0, 48'h0100_0000_0000, 40'h7f_ffff_ffff);
    sat_case(SSF_DST_ACC1, 1'b0, 48'hff00_0000_0000, 40'h80_0000_0000);
    sat_case(SSF_DST_ACC0, 1'b1, 48'h0000_8000_0000, 40'h00_7fff_ffff);
    chk_val("acc0 sat32", 40'h00_7fff_ffff, acc_reg[0]);
    $display("test sat done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #2_000_000;
    num_errors++;
    $display("ERROR watchdog expected done seen hang");
    finish_test;
  end

  // main sequence
  initial begin
    addr       = 8'h00;
    wdata      = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    arst_n     = 1'b0;
    num_errors = 0;
    checks     = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk_flags("reset flags", 12'h0, stat_reg);
    t_regs;
    t_data;
    t_acc;
    t_agen;
    t_sat;
    finish_test;
  end
endmodule
